// >>> rtl/phio_port.sv
// Parallel handshake I/O port: host command side, peripheral pins, status and interrupts.
//
// Functional notes
// - Latch sixteen input lines, drive sixteen output lines, keep output during input.
// - Select codes 0-7 request low-priority interrupt, 8-15 high-priority.
// - Within a level higher select code wins; 7 and 15 rank highest.
// - Select code comes up as 2 after reset.
// - Status read at own code returns at least 288; other codes give zero.
// - Direction line low for host output, high for host input.
// - Output strobe set only while new output data sits on the lines.
// - Input strobe set only while a new input word is requested.
// - Full mode waits for flag ready before setting the strobe.
// - Pulse mode sets strobe without checking flag; a flag transition ends it.
// - Interrupt enabled and DMA off: request interrupt when idle and flag shows ready.
// - Host bus flag busy during a handshake; reset clears interrupt and DMA enables.
`timescale 1ns/1ps
module phio_port
    import phio_pkg::*;
#(
    parameter int          WIDTH    = DATA_W,
    parameter logic [3:0]  SEL_INIT = SEL_CODE_RST
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Host output words
    input  wire logic             out_valid,
    input  wire logic [WIDTH-1:0] out_data,
    output logic                  out_ready,
    // Host input words
    input  wire logic             in_req,
    output logic                  in_req_ready,
    output logic                  in_valid,
    output logic [WIDTH-1:0]      in_data,
    input  wire logic             in_take,
    // Mode and select code
    input  wire logic             mode_wr,
    input  wire logic             mode_int_en,
    input  wire logic             mode_dma_en,
    input  wire logic             mode_pulse,
    input  wire logic             sel_wr,
    input  wire logic [3:0]       sel_code_in,
    // Status read
    input  wire logic             stat_rd,
    input  wire logic [3:0]       stat_addr,
    output logic                  stat_valid,
    output logic [15:0]           stat_data,
    // Host bus signalling
    output logic                  host_bus_flag,
    output logic                  irq_low,
    output logic                  irq_high,
    output logic [2:0]            irq_rank,
    output logic                  dma_req,
    // Peripheral pins
    input  wire logic [WIDTH-1:0] data_input_lines,
    output logic [WIDTH-1:0]      data_output_lines,
    output logic                  control_strobe,
    output logic                  xfer_dir,
    input  wire logic             peripheral_flag
);

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_WAIT_RDY,
        HS_SETTLE,
        HS_STROBE
    } phio_hs_e;

    phio_hs_e         state_ff;
    phio_hs_e         nxt_state;
    logic [DLY_W-1:0] dly_ff;
    logic             flag_prev_ff;
    logic             int_en_ff;
    logic             dma_en_ff;
    logic [3:0]       sel_code_ff;
    logic             flag_ready;
    logic             flag_edge;
    logic             start_out;
    logic             start_in;
    logic             done;
    logic             push_valid;
    logic             buf_ready;
    logic             buf_valid;
    logic             idle_ready;
    logic [15:0]      stat_word;
    logic             stat_hit;

    // ----------------------------------------------------------------
    // Flag decoding
    // ----------------------------------------------------------------
    assign flag_ready = (peripheral_flag != FLAG_BUSY_LVL);
    assign flag_edge  = (peripheral_flag != flag_prev_ff);
    assign done       = (state_ff == HS_STROBE) && flag_edge;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_prev_ff <= peripheral_flag;
        end else begin
            flag_prev_ff <= peripheral_flag;
        end
    end

    // ----------------------------------------------------------------
    // Transfer starts
    // ----------------------------------------------------------------
    assign out_ready    = (state_ff == HS_IDLE);
    assign in_req_ready = (state_ff == HS_IDLE) && !out_valid && buf_ready;
    assign start_out    = out_valid && out_ready;
    assign start_in     = in_req && in_req_ready;

    // ----------------------------------------------------------------
    // Handshake sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            HS_IDLE: begin
                if (start_out || start_in) begin
                    nxt_state = mode_pulse ? HS_SETTLE : HS_WAIT_RDY;
                end
            end
            HS_WAIT_RDY: begin
                if (flag_ready) begin
                    nxt_state = HS_SETTLE;
                end
            end
            HS_SETTLE: begin
                if (dly_ff == '0) begin
                    nxt_state = HS_STROBE;
                end
            end
            HS_STROBE: begin
                if (done) begin
                    nxt_state = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= HS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dly_ff <= '0;
        end else if (state_ff != HS_SETTLE) begin
            dly_ff <= DLY_W'(OUT_DELAY_CYC - 1);
        end else if (dly_ff != '0) begin
            dly_ff <= dly_ff - DLY_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Peripheral side outputs and host bus flag
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_strobe <= 1'b0;
        end else begin
            control_strobe <= (nxt_state == HS_STROBE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xfer_dir <= DIR_OUTPUT;
        end else if (start_out) begin
            xfer_dir <= DIR_OUTPUT;
        end else if (start_in) begin
            xfer_dir <= DIR_INPUT;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_output_lines <= '0;
        end else if (start_out) begin
            data_output_lines <= out_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            host_bus_flag <= 1'b0;
        end else begin
            host_bus_flag <= (nxt_state != HS_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Input word buffer
    // ----------------------------------------------------------------
    assign push_valid = done && (xfer_dir == DIR_INPUT);

    phio_buf #(
        .WIDTH (WIDTH),
        .DEPTH (2)
    ) u_in_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_valid (push_valid),
        .wr_data  (data_input_lines),
        .wr_ready (buf_ready),
        .rd_valid (buf_valid),
        .rd_data  (in_data),
        .rd_ready (in_take)
    );

    assign in_valid = buf_valid;

    // ----------------------------------------------------------------
    // Mode and select code
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_en_ff <= 1'b0;
            dma_en_ff <= 1'b0;
        end else if (mode_wr) begin
            int_en_ff <= mode_int_en;
            dma_en_ff <= mode_dma_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_code_ff <= SEL_INIT;
        end else if (sel_wr) begin
            sel_code_ff <= sel_code_in;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt and DMA requests
    // ----------------------------------------------------------------
    assign idle_ready = (state_ff == HS_IDLE) && flag_ready;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_low  <= 1'b0;
            irq_high <= 1'b0;
        end else begin
            irq_low  <= int_en_ff && !dma_en_ff && idle_ready
                        && (sel_code_ff < SEL_HIGH_MIN);
            irq_high <= int_en_ff && !dma_en_ff && idle_ready
                        && (sel_code_ff >= SEL_HIGH_MIN);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dma_req <= 1'b0;
        end else begin
            dma_req <= dma_en_ff && idle_ready;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_rank <= '0;
        end else begin
            irq_rank <= sel_code_ff[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    always_comb begin
        stat_word               = STATUS_BASE;
        stat_word[ST_FLAG_BUSY] = !flag_ready;
        stat_word[ST_HOST_BUSY] = host_bus_flag;
        stat_word[ST_IN_VALID]  = buf_valid;
        stat_word[ST_INT_EN]    = int_en_ff;
        stat_word[ST_DMA_EN]    = dma_en_ff;
    end

    assign stat_hit = (stat_addr == sel_code_ff);

    // ----------------------------------------------------------------
    // Status read
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_valid <= 1'b0;
            stat_data  <= '0;
        end else begin
            stat_valid <= stat_rd;
            if (stat_rd && stat_hit) begin
                stat_data <= stat_word;
            end else if (stat_rd) begin
                stat_data <= '0;
            end
        end
    end

endmodule // phio_port

// >>> rtl/phio_pkg.sv
// Shared constants for the parallel handshake I/O port.
package phio_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int          DATA_W        = 16;
    localparam int          SEL_W         = 4;
    localparam logic [3:0]  SEL_CODE_RST  = 4'h2;
    localparam logic [3:0]  SEL_HIGH_MIN  = 4'h8;
    localparam logic        FLAG_BUSY_LVL = 1'b1;
    localparam logic        DIR_OUTPUT    = 1'b0;
    localparam logic        DIR_INPUT     = 1'b1;

    // ----------------------------------------------------------------
    // Status word layout
    // ----------------------------------------------------------------
    localparam logic [15:0] STATUS_BASE   = 16'h0120;
    localparam int          ST_FLAG_BUSY  = 0;
    localparam int          ST_HOST_BUSY  = 1;
    localparam int          ST_IN_VALID   = 2;
    localparam int          ST_INT_EN     = 3;
    localparam int          ST_DMA_EN     = 4;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          OUT_DELAY_NS  = 100;
    localparam int          OUT_DELAY_CYC = (OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DLY_W         = 4;

endpackage

// >>> rtl/phio_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module phio_buf
    import phio_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  wr_ready,
    // Drain side
    output logic                  rd_valid,
    output logic [WIDTH-1:0]      rd_data,
    input  wire logic             rd_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wptr_ff;
    logic [PW-1:0]    rptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    assign wr_ready = (count_ff != CW'(DEPTH));
    assign rd_valid = (count_ff != '0);
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= (pop && count_ff > CW'(1)) ? mem_ff[rptr_ff + PW'(1)]
                     : (count_ff == '0 || (pop && count_ff == CW'(1))) ? wr_data
                     : rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Pointers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= (wptr_ff == PW'(DEPTH - 1)) ? '0 : wptr_ff + PW'(1);
            end
            if (pop) begin
                rptr_ff <= (rptr_ff == PW'(DEPTH - 1)) ? '0 : rptr_ff + PW'(1);
            end
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end

endmodule // phio_buf

// >>> tb/phio_periph.sv
// Behavioural peripheral that answers the port on its flag line.
`timescale 1ns/1ps
module phio_periph
    import phio_pkg::*;
(
    // Port pins
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              control_strobe,
    input  wire logic              xfer_dir,
    input  wire logic [DATA_W-1:0] data_output_lines,
    output logic                   peripheral_flag,
    output logic [DATA_W-1:0]      data_input_lines,
    // Test knobs
    input  wire logic              rest_lvl,
    input  wire logic [3:0]        dly,
    input  wire logic [DATA_W-1:0] in_word,
    output logic [DATA_W-1:0]      got_word
);
    logic [3:0] cnt_ff;
    logic       act_ff;
    logic       hit;

    assign hit = (cnt_ff == dly);
    // Flag flips dly+1 cycles after the strobe is seen, then returns to rest.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            peripheral_flag <= rest_lvl;
            cnt_ff <= 4'h0;
            act_ff <= 1'h0;
        end else if (control_strobe || act_ff) begin
            cnt_ff <= hit ? 4'h0 : cnt_ff + 4'h1;
            act_ff <= act_ff ^ hit;
            if (hit) begin
                peripheral_flag <= act_ff ? rest_lvl : ~peripheral_flag;
            end
        end
    end
    // Output words are taken while the strobe offers them.
    always_ff @(posedge core_clk) begin
        if (control_strobe && !xfer_dir) begin
            got_word <= data_output_lines;
        end
    end
    // Undriven lines float to the pull-up level.
    assign data_input_lines = (xfer_dir && (control_strobe || act_ff)) ? in_word : {DATA_W{1'b1}};
endmodule // phio_periph

// >>> tb/phio_chk.sv
// Concurrent checks on the parallel handshake I/O port.
`timescale 1ns/1ps
module phio_chk
    import phio_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        out_valid,
    input wire logic [15:0] out_data,
    input wire logic        out_ready,
    input wire logic        in_req,
    input wire logic        in_req_ready,
    input wire logic        mode_pulse,
    input wire logic        sel_wr,
    input wire logic [3:0]  sel_code_in,
    input wire logic        stat_rd,
    input wire logic [3:0]  stat_addr,
    input wire logic        stat_valid,
    input wire logic [15:0] stat_data,
    input wire logic        host_bus_flag,
    input wire logic        irq_low,
    input wire logic        irq_high,
    input wire logic [2:0]  irq_rank,
    input wire logic [15:0] data_output_lines,
    input wire logic        control_strobe,
    input wire logic        xfer_dir,
    input wire logic        peripheral_flag
);
    logic [3:0] sel_ff;
    logic [3:0] sel_d_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_ff <= SEL_CODE_RST;
            sel_d_ff <= SEL_CODE_RST;
        end else begin
            sel_ff <= sel_wr ? sel_code_in : sel_ff;
            sel_d_ff <= sel_ff;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_take;
        out_valid && out_ready;
    endsequence
    sequence s_full_rise;
        host_bus_flag && $rose(control_strobe) && !mode_pulse;
    endsequence

    a_dir_out: assert property (
        s_take |=> xfer_dir == DIR_OUTPUT && host_bus_flag) else $error("bad output start");
    a_dir_in: assert property (
        in_req && in_req_ready && !out_valid |=> xfer_dir == DIR_INPUT && host_bus_flag)
        else $error("bad input start");
    a_word_out: assert property (
        s_take |=> data_output_lines == $past(out_data)) else $error("output word wrong");
    a_word_hold: assert property (
        !(out_valid && out_ready) |=> $stable(data_output_lines)) else $error("output moved");
    a_strobe_busy: assert property (
        control_strobe |-> host_bus_flag) else $error("strobe while idle");
    a_strobe_end: assert property (
        control_strobe && $changed(peripheral_flag) |-> ##[1:2] !control_strobe)
        else $error("strobe not cleared");
    a_full_wait: assert property (
        s_full_rise |-> !$past(peripheral_flag, 2)) else $error("strobe while busy");
    a_pulse_go: assert property (
        s_take ##0 mode_pulse |-> ##2 control_strobe) else $error("pulse strobe late");
    a_stat_own: assert property (
        stat_rd && stat_addr == sel_ff |=> stat_valid && stat_data >= 16'h0120)
        else $error("own status low");
    a_stat_none: assert property (
        stat_rd && stat_addr != sel_ff |=> stat_valid && stat_data == 16'h0)
        else $error("foreign status not zero");
    a_irq_level: assert property (
        irq_low || irq_high |-> irq_high == (sel_d_ff >= SEL_HIGH_MIN)
        && irq_rank == sel_d_ff[2:0]) else $error("irq level wrong");
endmodule // phio_chk

// >>> tb/tb.sv
// Self-checking bench for the parallel handshake I/O port.
`timescale 1ns/1ps
module tb
    import phio_pkg::*;
;
    logic core_clk = 1'h0, rst = 1'h1, out_valid = 1'h0, in_req = 1'h0, in_take = 1'h0;
    logic mode_wr = 1'h0, mode_int_en = 1'h0, mode_dma_en = 1'h0, mode_pulse = 1'h0;
    logic sel_wr = 1'h0, stat_rd = 1'h0, rest_lvl = 1'h0;
    logic [3:0] sel_code_in = 4'h0, stat_addr = 4'h0;
    logic [15:0] out_data = 16'h0, in_word = 16'h0;
    logic out_ready, in_req_ready, in_valid, stat_valid, host_bus_flag, irq_low, irq_high;
    logic dma_req, control_strobe, xfer_dir, peripheral_flag;
    logic per_flag, tie_flag = 1'h0;
    logic [15:0] in_data, stat_data, data_input_lines, data_output_lines, got_word;
    logic [2:0] irq_rank;
    int mismatches = 0;
    int n_compared = 0;

    always #50 core_clk = ~core_clk;

    phio_port uut (.*);
    phio_periph u_per (.core_clk, .rst, .control_strobe, .xfer_dir, .data_output_lines,
        .peripheral_flag(per_flag), .data_input_lines, .rest_lvl, .dly(4'h3), .in_word, .got_word);
    // A peripheral with no handshake of its own has its flag tied to the strobe.
    assign peripheral_flag = tie_flag ? control_strobe : per_flag;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge core_clk) rst <= 1'h1;
        @(posedge core_clk);
        @(posedge core_clk) rst <= 1'h0;
        #1;
    endtask
    task automatic set_sel(input logic [3:0] c);
        @(posedge core_clk) {sel_wr, sel_code_in} <= {1'h1, c};
        @(posedge core_clk) sel_wr <= 1'h0;
        cyc(3);
    endtask
    task automatic set_mode(input logic ie, input logic de);
        @(posedge core_clk) {mode_wr, mode_int_en, mode_dma_en} <= {1'h1, ie, de};
        @(posedge core_clk) mode_wr <= 1'h0;
        cyc(3);
    endtask
    task automatic stat(input logic [3:0] a, input logic own);
        @(posedge core_clk) {stat_rd, stat_addr} <= {1'h1, a};
        @(posedge core_clk) stat_rd <= 1'h0;
        #1;
        check(stat_valid, 1'h1);
        check(own ? {15'h0, stat_data >= 16'h0120} : stat_data, {15'h0, own});
    endtask
    task automatic do_out(input logic [15:0] w);
        int i;
        @(posedge core_clk) {out_valid, out_data} <= {1'h1, w};
        #1;
        for (i = 0; i < 60 && !out_ready; i++) cyc(1);
        @(posedge core_clk) out_valid <= 1'h0;
        #1;
        check(data_output_lines, w);
        check(xfer_dir, DIR_OUTPUT);
        check(host_bus_flag, 1'h1);
        for (i = 0; i < 60 && host_bus_flag; i++) cyc(1);
        check(control_strobe, 1'h0);
        check(got_word, w);
    endtask
    task automatic do_in(input logic [15:0] w);
        int i;
        @(posedge core_clk) {in_req, in_word} <= {1'h1, w};
        #1;
        for (i = 0; i < 60 && !in_req_ready; i++) cyc(1);
        @(posedge core_clk) in_req <= 1'h0;
        #1;
        check(xfer_dir, DIR_INPUT);
        for (i = 0; i < 60 && host_bus_flag; i++) cyc(1);
        check(control_strobe, 1'h0);
    endtask
    task automatic pop(input logic [15:0] w);
        cyc(2);
        check(in_valid, 1'h1);
        check(in_data, w);
        @(posedge core_clk) in_take <= 1'h1;
        @(posedge core_clk) in_take <= 1'h0;
    endtask

    task automatic t_reset_vals;
        check(out_ready, 1'h1);
        check(control_strobe, 1'h0);
        check(irq_low | irq_high | dma_req, 1'h0);
        stat(4'h2, 1'h1);
        stat(4'h3, 1'h0);
    endtask
    task automatic t_full_out;
        do_out(16'ha5c3);
        do_out(16'h5a3c);
    endtask
    task automatic t_duplex_in;
        do_in(16'h1234);
        do_in(16'hbeef);
        @(posedge core_clk) in_req <= 1'h1;
        cyc(4);
        check(in_req_ready, 1'h0);
        check(control_strobe, 1'h0);
        check(data_output_lines, 16'h5a3c);
        @(posedge core_clk) in_req <= 1'h0;
        pop(16'h1234);
        pop(16'hbeef);
        cyc(2);
        check(in_valid, 1'h0);
    endtask
    task automatic t_irq;
        logic [3:0] codes [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
        set_mode(1'h1, 1'h0);
        foreach (codes[k]) begin
            set_sel(codes[k]);
            check(irq_low, codes[k] < SEL_HIGH_MIN);
            check(irq_high, codes[k] >= SEL_HIGH_MIN);
            check(irq_rank, codes[k][2:0]);
            stat(codes[k], 1'h1);
        end
        stat(4'h2, 1'h0);
        set_mode(1'h1, 1'h1);
        check(irq_high, 1'h0);
        check(dma_req, 1'h1);
        do_reset;
        check(irq_low | irq_high | dma_req, 1'h0);
        stat(4'h2, 1'h1);
    endtask
    task automatic t_pulse;
        @(posedge core_clk) {rest_lvl, mode_pulse} <= 2'h3;
        do_reset;
        set_mode(1'h1, 1'h0);
        check(irq_low, 1'h0);
        do_out(16'h0ff0);
        cyc(8);
        do_in(16'hc001);
        pop(16'hc001);
    endtask

    task automatic t_tie;
        @(posedge core_clk) {tie_flag, mode_pulse} <= 2'h2;
        cyc(2);
        check(irq_low, 1'h1);
        do_out(16'h3cc3);
        do_in(16'h7e81);
        pop(16'h7e81);
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // A single port holds the default select code except in t_irq, so no code is shared.
    initial begin
        do_reset;
        t_reset_vals;
        t_full_out;
        t_duplex_in;
        t_irq;
        t_pulse;
        t_tie;
        end_sim;
    end
    initial begin
        #2000000;
        mismatches++;
        end_sim;
    end
endmodule // tb

bind phio_port phio_chk u_chk (.*);
